// ===== common/mmrb_pkg.sv
package mmrb_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFF_REMOTE9_HIGH = 8'h61;
	localparam logic [7:0] OFF_REMOTE4_BETA = 8'h64;
	localparam logic [7:0] OFF_REMOTE5_BETA = 8'h65;
	localparam logic [7:0] OFF_REMOTE6_BETA = 8'h66;
	localparam logic [7:0] OFF_RES_CORR_EN = 8'h70;
	localparam logic [7:0] OFF_PROG_VOLT = 8'h71;
	localparam logic [7:0] OFF_PULSE1_DIV = 8'h72;
	localparam logic [7:0] OFF_PULSE2_DIV = 8'h73;
	localparam logic [7:0] OFF_TRIP_THRESH = 8'h75;
	localparam logic [7:0] OFF_TRIP_CAUSE = 8'h76;
	localparam logic [7:0] OFF_TRIP_CONFIG = 8'h77;
	localparam logic [7:0] OFF_BUS_ERROR = 8'h7A;
	localparam logic [7:0] OFF_GLOBAL_IRQ = 8'h7C;
	localparam logic [7:0] OFF_UPD_EN_B = 8'h7D;
	localparam logic [7:0] OFF_UPD_EN_A = 8'h7E;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_REMOTE9_HIGH = 8'h7F;
	localparam logic [7:0] RST_BETA = 8'h10;
	localparam logic [7:0] RST_RES_CORR_EN = 8'hFF;
	localparam logic [7:0] RST_PROG_VOLT = 8'hFF;
	localparam logic [7:0] RST_PULSE1_DIV = 8'h28;
	localparam logic [7:0] RST_PULSE2_DIV = 8'h01;
	localparam logic [7:0] RST_TRIP_THRESH = 8'h7F;
	localparam logic [7:0] RST_TRIP_CAUSE = 8'h00;
	localparam logic [7:0] RST_TRIP_CONFIG = 8'h00;
	localparam logic [7:0] RST_BUS_ERROR = 8'h00;
	localparam logic [7:0] RST_GLOBAL_IRQ = 8'h04;
	localparam logic [7:0] RST_UPD_EN_B = 8'h00;
	localparam logic [7:0] RST_UPD_EN_A = 8'hC0;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int GIRQ_CAUSE_CLR_BIT = 0;
	localparam int GIRQ_ENABLE_BIT = 2;
	localparam int UPD_A_VOLT_IRQ_BIT = 7;
	localparam int UPD_A_TEMP_IRQ_BIT = 6;
	localparam int BETA_COUNT = 3;

	////////////////////////////////////////////////////////////////////////
	// read answer states
	typedef enum logic [1:0] {
		MMRB_ST_IDLE = 2'b01,
		MMRB_ST_RESP = 2'b10
	} mmrb_state_t;

endpackage

// ===== rtl/mmrb_divider.sv
`timescale 1ns/1ps
`default_nettype none
module mmrb_divider #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic base_tick,
	input wire logic [WIDTH-1:0] ratio,
	output logic pulse_out
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic pulse_reg;
	logic pulse_next;
	logic [WIDTH-1:0] last;

	// ratio 0 acts as ratio 1
	always_comb begin
		last = (ratio == '0) ? '0 : ratio - WIDTH'(1);
		count_next = count_reg;
		pulse_next = 1'b0;
		if (base_tick) begin
			if (count_reg >= last) begin
				count_next = '0;
				pulse_next = 1'b1;
			end else begin
				count_next = count_reg + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_out = pulse_reg;

	chk_div_pulse_cause: assert property (@(posedge clk) disable iff (!rstn)
		pulse_reg |-> $past(base_tick))
		else $error("divided pulse without base tick");
endmodule
`default_nettype wire

// ===== rtl/mmrb_top.sv
// Function
// - remote diode 9 high limit is a writable lockable byte resetting to 7Fh.
// - diodes 4 to 6 each have a writable lockable beta byte resetting to 10h.
// - series resistance correction enables are writable and reset to FFh.
// - the programming voltage reading is read only, resets to FFh, writes do nothing.
// - pulse output 1 is divided by a writable ratio register resetting to 28h.
// - pulse output 2 has its own writable lockable divide ratio register.
// - the trip limit is derived from the programming voltage, compared to diode 1, read only, 7Fh.
// - read only cause bits, 00h at reset, record which trip input asserted the outputs.
// - the fallback protection config is writable, lockable, 00h, kept in every power mode.
// - read only bits flag each bus error type detected, 00h at reset.
// - one unlockable register holds global interrupt enable and cause clear, reset 04h.
// - regulator, fan driver, shutdown and diodes 3 to 7 update status only when enabled.
// - voltage and temperature channels interrupt only when their enables are set, reset C0h.
// - internal diode, diodes 1 and 2 and voltages update status only when enabled.
// - lockable registers fall under the software lock engaged from the lock start register.
`timescale 1ns/1ps
`default_nettype none
module mmrb_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_valid,
	input wire logic lock_engage,
	input wire logic vset_valid,
	input wire logic [7:0] vset_sample,
	input wire logic [7:0] remote1_temp,
	input wire logic [7:0] trip_cause_event,
	input wire logic [7:0] bus_error_event,
	input wire logic [7:0] status_event_a,
	input wire logic [7:0] status_event_b,
	input wire logic volt_pending,
	input wire logic temp_pending,
	input wire logic other_pending,
	input wire logic pulse1_base_tick,
	input wire logic pulse2_base_tick,
	output logic [7:0] remote9_high_limit,
	output logic [7:0] remote4_beta,
	output logic [7:0] remote5_beta,
	output logic [7:0] remote6_beta,
	output logic [7:0] series_resistance_cancel,
	output logic [7:0] fallback_protection_config,
	output logic [7:0] status_update_a,
	output logic [7:0] status_update_b,
	output logic overtemp_trip,
	output logic lockable_flag,
	output logic irq_out_n,
	output logic pulse_out1,
	output logic pulse_out2
);

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic is_lockable(input logic [7:0] a);
		case (a)
			mmrb_pkg::OFF_REMOTE9_HIGH,
			mmrb_pkg::OFF_REMOTE4_BETA,
			mmrb_pkg::OFF_REMOTE5_BETA,
			mmrb_pkg::OFF_REMOTE6_BETA,
			mmrb_pkg::OFF_RES_CORR_EN,
			mmrb_pkg::OFF_PULSE1_DIV,
			mmrb_pkg::OFF_PULSE2_DIV,
			mmrb_pkg::OFF_TRIP_CONFIG,
			mmrb_pkg::OFF_UPD_EN_B,
			mmrb_pkg::OFF_UPD_EN_A: is_lockable = 1'b1;
			default: is_lockable = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] trip_limit(input logic [7:0] v);
		trip_limit = {1'b0, v[7:1]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] hi9_reg, hi9_next;
	logic [7:0] beta_reg [0:mmrb_pkg::BETA_COUNT-1];
	logic [7:0] beta_next [0:mmrb_pkg::BETA_COUNT-1];
	logic [7:0] rec_reg, rec_next;
	logic [7:0] vset_reg, vset_next;
	logic [7:0] div1_reg, div1_next;
	logic [7:0] div2_reg, div2_next;
	logic [7:0] thr_reg, thr_next;
	logic [7:0] cause_reg, cause_next;
	logic [7:0] fcfg_reg, fcfg_next;
	logic [7:0] berr_reg, berr_next;
	logic [7:0] girq_reg, girq_next;
	logic [7:0] ena_b_reg, ena_b_next;
	logic [7:0] ena_a_reg, ena_a_next;
	logic lock_reg, lock_next;
	logic [7:0] upd_a_reg, upd_a_next;
	logic [7:0] upd_b_reg, upd_b_next;
	logic trip_reg, trip_next;
	logic irq_n_reg, irq_n_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	mmrb_pkg::mmrb_state_t state_reg, state_next;
	logic wr_ok;
	logic rd_take;
	logic cause_clr;
	logic [7:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// register writes and hardware updates
	always_comb begin
		wr_ok = wr_en && !(lock_reg && is_lockable(addr));
		rd_take = rd_en && (state_reg == mmrb_pkg::MMRB_ST_IDLE);
		cause_clr = wr_en && (addr == mmrb_pkg::OFF_GLOBAL_IRQ) &&
			wdata[mmrb_pkg::GIRQ_CAUSE_CLR_BIT];
		hi9_next = hi9_reg;
		rec_next = rec_reg;
		div1_next = div1_reg;
		div2_next = div2_reg;
		fcfg_next = fcfg_reg;
		girq_next = girq_reg;
		ena_b_next = ena_b_reg;
		ena_a_next = ena_a_reg;
		for (int i = 0; i < mmrb_pkg::BETA_COUNT; i++) begin
			beta_next[i] = beta_reg[i];
			if (wr_ok && addr == mmrb_pkg::OFF_REMOTE4_BETA + 8'(i))
				beta_next[i] = wdata;
		end
		if (wr_ok) begin
			case (addr)
				mmrb_pkg::OFF_REMOTE9_HIGH: hi9_next = wdata;
				mmrb_pkg::OFF_RES_CORR_EN: rec_next = wdata;
				mmrb_pkg::OFF_PULSE1_DIV: div1_next = wdata;
				mmrb_pkg::OFF_PULSE2_DIV: div2_next = wdata;
				mmrb_pkg::OFF_TRIP_CONFIG: fcfg_next = wdata;
				mmrb_pkg::OFF_UPD_EN_B: ena_b_next = wdata;
				mmrb_pkg::OFF_UPD_EN_A: ena_a_next = wdata;
				mmrb_pkg::OFF_GLOBAL_IRQ: begin
					// clear bit is a strobe, never stored
					girq_next = wdata;
					girq_next[mmrb_pkg::GIRQ_CAUSE_CLR_BIT] = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// read only values follow the hardware only
		vset_next = vset_valid ? vset_sample : vset_reg;
		thr_next = vset_valid ? trip_limit(vset_sample) : thr_reg;
		trip_next = $signed(remote1_temp) >= $signed(thr_reg);
		// set wins over clear
		cause_next = (cause_clr ? 8'h00 : cause_reg) | trip_cause_event;
		berr_next = ((rd_take && addr == mmrb_pkg::OFF_BUS_ERROR) ? 8'h00 : berr_reg) |
			bus_error_event;
		lock_next = lock_reg | lock_engage;
		upd_a_next = status_event_a & ena_a_reg;
		upd_b_next = status_event_b & ena_b_reg;
		irq_n_next = !(girq_reg[mmrb_pkg::GIRQ_ENABLE_BIT] &&
			((volt_pending && ena_a_reg[mmrb_pkg::UPD_A_VOLT_IRQ_BIT]) ||
			(temp_pending && ena_a_reg[mmrb_pkg::UPD_A_TEMP_IRQ_BIT]) ||
			other_pending));
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hi9_reg <= mmrb_pkg::RST_REMOTE9_HIGH;
			for (int i = 0; i < mmrb_pkg::BETA_COUNT; i++) begin
				beta_reg[i] <= mmrb_pkg::RST_BETA;
			end
			rec_reg <= mmrb_pkg::RST_RES_CORR_EN;
			vset_reg <= mmrb_pkg::RST_PROG_VOLT;
			div1_reg <= mmrb_pkg::RST_PULSE1_DIV;
			div2_reg <= mmrb_pkg::RST_PULSE2_DIV;
			thr_reg <= mmrb_pkg::RST_TRIP_THRESH;
			cause_reg <= mmrb_pkg::RST_TRIP_CAUSE;
			fcfg_reg <= mmrb_pkg::RST_TRIP_CONFIG;
			berr_reg <= mmrb_pkg::RST_BUS_ERROR;
			girq_reg <= mmrb_pkg::RST_GLOBAL_IRQ;
			ena_b_reg <= mmrb_pkg::RST_UPD_EN_B;
			ena_a_reg <= mmrb_pkg::RST_UPD_EN_A;
			lock_reg <= 1'b0;
			upd_a_reg <= 8'h00;
			upd_b_reg <= 8'h00;
			trip_reg <= 1'b0;
			irq_n_reg <= 1'b1;
		end else begin
			hi9_reg <= hi9_next;
			for (int i = 0; i < mmrb_pkg::BETA_COUNT; i++) begin
				beta_reg[i] <= beta_next[i];
			end
			rec_reg <= rec_next;
			vset_reg <= vset_next;
			div1_reg <= div1_next;
			div2_reg <= div2_next;
			thr_reg <= thr_next;
			cause_reg <= cause_next;
			fcfg_reg <= fcfg_next;
			berr_reg <= berr_next;
			girq_reg <= girq_next;
			ena_b_reg <= ena_b_next;
			ena_a_reg <= ena_a_next;
			lock_reg <= lock_next;
			upd_a_reg <= upd_a_next;
			upd_b_reg <= upd_b_next;
			trip_reg <= trip_next;
			irq_n_reg <= irq_n_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read answer
	always_comb begin
		case (addr)
			mmrb_pkg::OFF_REMOTE9_HIGH: rd_mux = hi9_reg;
			mmrb_pkg::OFF_REMOTE4_BETA: rd_mux = beta_reg[0];
			mmrb_pkg::OFF_REMOTE5_BETA: rd_mux = beta_reg[1];
			mmrb_pkg::OFF_REMOTE6_BETA: rd_mux = beta_reg[2];
			mmrb_pkg::OFF_RES_CORR_EN: rd_mux = rec_reg;
			mmrb_pkg::OFF_PROG_VOLT: rd_mux = vset_reg;
			mmrb_pkg::OFF_PULSE1_DIV: rd_mux = div1_reg;
			mmrb_pkg::OFF_PULSE2_DIV: rd_mux = div2_reg;
			mmrb_pkg::OFF_TRIP_THRESH: rd_mux = thr_reg;
			mmrb_pkg::OFF_TRIP_CAUSE: rd_mux = cause_reg;
			mmrb_pkg::OFF_TRIP_CONFIG: rd_mux = fcfg_reg;
			mmrb_pkg::OFF_BUS_ERROR: rd_mux = berr_reg;
			mmrb_pkg::OFF_GLOBAL_IRQ: rd_mux = girq_reg;
			mmrb_pkg::OFF_UPD_EN_B: rd_mux = ena_b_reg;
			mmrb_pkg::OFF_UPD_EN_A: rd_mux = ena_a_reg;
			default: rd_mux = mmrb_pkg::RD_UNMAPPED;
		endcase
		state_next = state_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		case (state_reg)
			mmrb_pkg::MMRB_ST_IDLE: begin
				if (rd_en) begin
					rdata_next = rd_mux;
					rvalid_next = 1'b1;
					state_next = mmrb_pkg::MMRB_ST_RESP;
				end
			end
			mmrb_pkg::MMRB_ST_RESP: begin
				state_next = mmrb_pkg::MMRB_ST_IDLE;
			end
			default: begin
				state_next = mmrb_pkg::MMRB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= mmrb_pkg::MMRB_ST_IDLE;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pulse output dividers
	mmrb_divider #(.WIDTH(8)) u_div1 (
		.clk(clk),
		.rstn(rstn),
		.base_tick(pulse1_base_tick),
		.ratio(div1_reg),
		.pulse_out(pulse_out1)
	);

	mmrb_divider #(.WIDTH(8)) u_div2 (
		.clk(clk),
		.rstn(rstn),
		.base_tick(pulse2_base_tick),
		.ratio(div2_reg),
		.pulse_out(pulse_out2)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdata = rdata_reg;
	assign rd_valid = rvalid_reg;
	assign remote9_high_limit = hi9_reg;
	assign remote4_beta = beta_reg[0];
	assign remote5_beta = beta_reg[1];
	assign remote6_beta = beta_reg[2];
	assign series_resistance_cancel = rec_reg;
	assign fallback_protection_config = fcfg_reg;
	assign status_update_a = upd_a_reg;
	assign status_update_b = upd_b_reg;
	assign overtemp_trip = trip_reg;
	assign lockable_flag = lock_reg;
	assign irq_out_n = irq_n_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_lock_sticky: assert property (@(posedge clk) disable iff (!rstn)
		lock_reg |=> lock_reg)
		else $error("lock released without reset");

	chk_locked_write_ignored: assert property (@(posedge clk) disable iff (!rstn)
		(lock_reg && wr_en && addr == mmrb_pkg::OFF_REMOTE9_HIGH) |=> $stable(hi9_reg))
		else $error("locked write changed limit");

	chk_open_write_taken: assert property (@(posedge clk) disable iff (!rstn)
		(!lock_reg && !lock_engage && wr_en && addr == mmrb_pkg::OFF_REMOTE9_HIGH)
		|=> hi9_reg == $past(wdata))
		else $error("unlocked write not stored");

	chk_girq_unlockable: assert property (@(posedge clk) disable iff (!rstn)
		(lock_reg && wr_en && addr == mmrb_pkg::OFF_GLOBAL_IRQ)
		|=> girq_reg[mmrb_pkg::GIRQ_ENABLE_BIT] == $past(wdata[mmrb_pkg::GIRQ_ENABLE_BIT]))
		else $error("global irq write blocked by lock");

	chk_vset_read_only: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && addr == mmrb_pkg::OFF_PROG_VOLT && !vset_valid) |=> $stable(vset_reg))
		else $error("write altered voltage reading");

	chk_trip_limit: assert property (@(posedge clk) disable iff (!rstn)
		vset_valid |=> ##1 (overtemp_trip ==
		($signed($past(remote1_temp)) >= $signed(trip_limit($past(vset_sample, 2))))))
		else $error("trip compare wrong");

	chk_cause_set_wins: assert property (@(posedge clk) disable iff (!rstn)
		(trip_cause_event != 8'h00) |=> ((cause_reg & $past(trip_cause_event)) ==
		$past(trip_cause_event)))
		else $error("trip cause event lost");

	chk_cause_clear: assert property (@(posedge clk) disable iff (!rstn)
		(cause_clr && trip_cause_event == 8'h00) |=> cause_reg == 8'h00)
		else $error("cause not cleared");

	chk_bus_error_set: assert property (@(posedge clk) disable iff (!rstn)
		(bus_error_event != 8'h00) |=> ((berr_reg & $past(bus_error_event)) ==
		$past(bus_error_event)))
		else $error("bus error event lost");

	chk_update_gate: assert property (@(posedge clk) disable iff (!rstn)
		((status_update_a & ~$past(ena_a_reg)) == 8'h00) &&
		((status_update_b & ~$past(ena_b_reg)) == 8'h00))
		else $error("status update without enable");

	chk_irq_needs_enable: assert property (@(posedge clk) disable iff (!rstn)
		!irq_out_n |-> $past(girq_reg[mmrb_pkg::GIRQ_ENABLE_BIT]))
		else $error("interrupt without global enable");

	chk_read_answer: assert property (@(posedge clk) disable iff (!rstn)
		(rd_en && state_reg == mmrb_pkg::MMRB_ST_IDLE) |=> rd_valid ##1 !rd_valid)
		else $error("read answer timing wrong");

	chk_reset_values: assert property (@(posedge clk)
		(rstn && !$past(rstn)) |-> (rec_reg == mmrb_pkg::RST_RES_CORR_EN &&
		div1_reg == mmrb_pkg::RST_PULSE1_DIV && ena_a_reg == mmrb_pkg::RST_UPD_EN_A))
		else $error("reset value wrong");

endmodule
`default_nettype wire

// ===== testbench/mmrb_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mmrb_top_bench;
	logic clk, rstn, wr_en, rd_en, lock_engage, vset_valid;
	logic [7:0] addr, wdata, vset_sample, remote1_temp, trip_cause_event, bus_error_event;
	logic [7:0] status_event_a, status_event_b;
	logic volt_pending, temp_pending, other_pending, pulse1_base_tick, pulse2_base_tick;
	logic [7:0] rdata, remote9_high_limit, remote4_beta, remote5_beta, remote6_beta;
	logic [7:0] series_resistance_cancel, fallback_protection_config;
	logic [7:0] status_update_a, status_update_b;
	logic rd_valid, overtemp_trip, lockable_flag, irq_out_n, pulse_out1, pulse_out2;
	int failures, n_checks, cycles, p1_cnt, p2_cnt;
	logic [7:0] seed, r, shadow[15];
	logic [7:0] ra[15] = '{8'h61, 8'h64, 8'h65, 8'h66, 8'h70, 8'h71, 8'h72, 8'h73,
		8'h75, 8'h76, 8'h77, 8'h7A, 8'h7C, 8'h7D, 8'h7E};
	logic [7:0] rv[15] = '{8'h7F, 8'h10, 8'h10, 8'h10, 8'hFF, 8'hFF, 8'h28, 8'h01,
		8'h7F, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'hC0};
	bit rw[15] = '{1, 1, 1, 1, 1, 0, 1, 1, 0, 0, 1, 0, 1, 1, 1};

	mmrb_top i_dut (.clk, .rstn, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_valid,
		.lock_engage, .vset_valid, .vset_sample, .remote1_temp, .trip_cause_event,
		.bus_error_event, .status_event_a, .status_event_b, .volt_pending, .temp_pending,
		.other_pending, .pulse1_base_tick, .pulse2_base_tick, .remote9_high_limit,
		.remote4_beta, .remote5_beta, .remote6_beta, .series_resistance_cancel,
		.fallback_protection_config, .status_update_a, .status_update_b, .overtemp_trip,
		.lockable_flag, .irq_out_n, .pulse_out1, .pulse_out2);

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic exp_trip(input logic [7:0] t, input logic [7:0] s);
		return $signed(t) >= $signed({1'b0, s[7:1]});
	endfunction

	task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check1(input string what, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		int n;
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		n = 0;
		#1;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		check1("rd_valid", 1'b1, rd_valid);
		check8("rdata", e, rdata);
		@(posedge clk);
		#1;
		check1("rd_valid_end", 1'b0, rd_valid);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 15; i++) shadow[i] = rv[i];
	endtask

	task automatic ticks(input int n);
		@(posedge clk);
		pulse1_base_tick <= 1'b1;
		pulse2_base_tick <= 1'b1;
		repeat (n) @(posedge clk);
		pulse1_base_tick <= 1'b0;
		pulse2_base_tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// clock, timeout, pulse counters
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (pulse_out1 === 1'b1) p1_cnt++;
		if (pulse_out2 === 1'b1) p2_cnt++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rstn, wr_en, rd_en, lock_engage, vset_valid} = '0;
		{addr, wdata, vset_sample, remote1_temp, trip_cause_event, bus_error_event} = '0;
		{status_event_a, status_event_b} = '0;
		{volt_pending, temp_pending, other_pending, pulse1_base_tick, pulse2_base_tick} = '0;
		seed = 8'h5E;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		// reset values
		for (int i = 0; i < 15; i++) rd(ra[i], rv[i]);
		rd(8'h62, 8'h00);
		check8("remote9", 8'h7F, remote9_high_limit);
		check8("beta5", 8'h10, remote5_beta);
		check8("rec", 8'hFF, series_resistance_cancel);
		check8("fcfg", 8'h00, fallback_protection_config);
		// random writes, read-only places ignore them
		for (int i = 0; i < 15; i++) begin
			seed = lfsr(seed);
			shadow[i] = (rw[i] && ra[i] != 8'h7C) ? seed : rv[i];
			if (ra[i] != 8'h7C) wr(ra[i], seed);
		end
		for (int i = 0; i < 15; i++) rd(ra[i], shadow[i]);
		check8("remote9", shadow[0], remote9_high_limit);
		check8("beta4", shadow[1], remote4_beta);
		check8("beta5", shadow[2], remote5_beta);
		check8("beta6", shadow[3], remote6_beta);
		check8("rec", shadow[4], series_resistance_cancel);
		check8("fcfg", shadow[10], fallback_protection_config);
		// status update gating
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			@(posedge clk);
			status_event_a <= seed;
			status_event_b <= ~seed;
			@(posedge clk);
			status_event_a <= 8'h00;
			status_event_b <= 8'h00;
			#1;
			check8("upd_a", seed & shadow[14], status_update_a);
			check8("upd_b", ~seed & shadow[13], status_update_b);
		end
		// interrupt output over enables and pendings
		for (int j = 0; j < 32; j++) begin
			wr(8'h7E, j[3] ? 8'h00 : 8'hC0);
			wr(8'h7C, j[2] ? 8'h04 : 8'h00);
			@(posedge clk);
			volt_pending <= j[1];
			temp_pending <= j[0];
			other_pending <= j[4];
			@(posedge clk);
			#1;
			check1("irq_n", !(j[2] && ((|j[1:0] && !j[3]) || j[4])), irq_out_n);
		end
		volt_pending <= 1'b0;
		temp_pending <= 1'b0;
		other_pending <= 1'b0;
		// programming voltage and trip compare
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			r = lfsr(seed);
			if (k == 0) r = {1'b0, seed[7:1]};
			if (k == 1) r = {1'b0, seed[7:1]} - 8'h01;
			@(posedge clk);
			vset_valid <= 1'b1;
			vset_sample <= seed;
			remote1_temp <= r;
			@(posedge clk);
			vset_valid <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			check1("trip", exp_trip(r, seed), overtemp_trip);
			rd(8'h71, seed);
			rd(8'h75, {1'b0, seed[7:1]});
		end
		// sticky cause and bus error bits
		seed = lfsr(seed);
		@(posedge clk);
		trip_cause_event <= seed;
		bus_error_event <= ~seed;
		@(posedge clk);
		trip_cause_event <= 8'h00;
		bus_error_event <= 8'h00;
		rd(8'h76, seed);
		rd(8'h7A, ~seed);
		rd(8'h7A, 8'h00);
		wr(8'h7C, 8'h05);
		rd(8'h76, 8'h00);
		rd(8'h7C, 8'h04);
		// dividers
		do_reset();
		p1_cnt = 0;
		p2_cnt = 0;
		ticks(80);
		check8("p1_cnt", 8'd2, 8'(p1_cnt));
		check8("p2_cnt", 8'd80, 8'(p2_cnt));
		wr(8'h72, 8'h03);
		wr(8'h73, 8'h04);
		shadow[6] = 8'h03;
		shadow[7] = 8'h04;
		p1_cnt = 0;
		p2_cnt = 0;
		ticks(12);
		check8("p1_cnt", 8'd4, 8'(p1_cnt));
		check8("p2_cnt", 8'd3, 8'(p2_cnt));
		// software lock
		@(posedge clk);
		lock_engage <= 1'b1;
		@(posedge clk);
		lock_engage <= 1'b0;
		#1;
		check1("lock", 1'b1, lockable_flag);
		for (int i = 0; i < 15; i++) if (ra[i] != 8'h7C) wr(ra[i], ~shadow[i]);
		for (int i = 0; i < 15; i++) rd(ra[i], shadow[i]);
		wr(8'h7C, 8'h00);
		rd(8'h7C, 8'h00);
		do_reset();
		@(posedge clk);
		#1;
		check1("lock", 1'b0, lockable_flag);
		finish_test();
	end
endmodule
`default_nettype wire
